// >>> hsl_pkg.sv
package hsl_pkg;
    // apb register offsets (byte addresses)
    localparam logic [11:0] HSL_STRAP_OFF = 12'h000;
    localparam logic [11:0] HSL_CTRL_OFF = 12'h004;
    localparam logic [11:0] HSL_STAT_OFF = 12'h008;
    // strap status field positions
    localparam int HSL_P2_PLUS_POS = 0;
    localparam int HSL_P2_MINUS_POS = 1;
    localparam int HSL_P3_PLUS_POS = 2;
    localparam int HSL_P3_MINUS_POS = 3;
    localparam int HSL_P4_PLUS_POS = 4;
    localparam int HSL_P4_MINUS_POS = 5;
    localparam int HSL_RATE_POS = 6;
    // port disable field positions in status register
    localparam int HSL_P2_OFF_POS = 0;
    localparam int HSL_P3_OFF_POS = 1;
    localparam int HSL_P4_OFF_POS = 2;
    localparam int HSL_LATCHED_POS = 3;
    // control register field positions
    localparam int HSL_FLASH_EN_POS = 0;
    localparam int HSL_SUSPEND_POS = 1;
    localparam int HSL_POWERDOWN_POS = 2;
    // reset values
    localparam logic [2:0] HSL_CTRL_RST = 3'h0;
    localparam logic [6:0] HSL_STRAP_RST = 7'h00;
    // flash clock rates
    localparam int HSL_RATE_SLOW_MHZ = 30;
    localparam int HSL_RATE_FAST_MHZ = 60;
    localparam logic HSL_RATE_SLOW = 1'b0;
    localparam logic HSL_RATE_FAST = 1'b1;
    // input synchroniser depth
    localparam int HSL_SYNC_STAGES = 3;
    // enabled edges spent waiting before the single capture
    localparam logic [2:0] HSL_SETTLE_CYCLES = 3'h4;
    typedef enum logic [1:0] {
        HSL_WAIT = 2'b00,
        HSL_SETTLE = 2'b01,
        HSL_HELD = 2'b11
    } hsl_state_t;
endpackage

// >>> hsl_sync.sv
`timescale 1ns/10ps
module hsl_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [6:0] raw_in,
    output logic [6:0] stable_out
);
    logic [6:0] stage [hsl_pkg::HSL_SYNC_STAGES];

    genvar i;
    generate
        for (i = 0; i < hsl_pkg::HSL_SYNC_STAGES; i++)
        begin : g_stage
            if (i == 0)
            begin : g_first
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        stage[i] <= hsl_pkg::HSL_STRAP_RST;
                    else if (clk_en)
                        stage[i] <= raw_in;
                end
            end
            else
            begin : g_next
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        stage[i] <= hsl_pkg::HSL_STRAP_RST;
                    else if (clk_en)
                        stage[i] <= stage[i - 1];
                end
            end
        end
    endgenerate

    // a bit moves only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stable_out <= hsl_pkg::HSL_STRAP_RST;
        else if (clk_en)
            stable_out <= (stage[1] & stage[2]) | (stable_out & (stage[1] | stage[2]));
    end
endmodule // hsl_sync

// >>> hub_strap_latch.sv
// Operation
// RL1: port 2 is disabled when both of its strap bits were latched high.
// RL2: port 3 is disabled when both of its strap bits were latched high.
// RL3: port 4 is disabled when both of its strap bits were latched high.
// RL4: a strap bit of 0 enables its line, and a port stays on unless both bits are 1.
// RL5: the latched rate strap selects 30 MHz at 0 and 60 MHz at 1 for the flash clock.
// RL6: with the rate latched as 1 the shared pin floats during suspend.
// RL7: with the rate latched as 0 the shared pin is driven low during suspend.
// RL8: chip enable is active low and held high in powerdown while the flash is enabled.
// RL9: straps are captured once after reset release and held until the next reset.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module hub_strap_latch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port2_plus_off_strap,
    input wire logic port2_minus_off_strap,
    input wire logic port3_plus_off_strap,
    input wire logic port3_minus_off_strap,
    input wire logic port4_plus_off_strap,
    input wire logic port4_minus_off_strap,
    input wire logic flash_rate_strap,
    input wire logic flash_ce_req_n,
    input wire logic flash_rate_pin_out,
    output logic port2_disabled,
    output logic port3_disabled,
    output logic port4_disabled,
    output logic flash_rate_fast,
    output logic flash_ce_n,
    output logic flash_rate_pin_o,
    output logic flash_rate_pin_oe_n,
    output logic straps_valid
);
    hsl_pkg::hsl_state_t state;
    logic [6:0] strap_sync;
    logic [6:0] strap;
    logic [2:0] ctrl;
    logic [2:0] settle_cnt;
    logic capture;
    logic acc;
    logic hit;

    function automatic logic both_high(input logic a, input logic b);
        both_high = a & b;
    endfunction

    hsl_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .raw_in({flash_rate_strap, port4_minus_off_strap, port4_plus_off_strap,
            port3_minus_off_strap, port3_plus_off_strap, port2_minus_off_strap,
            port2_plus_off_strap}),
        .stable_out(strap_sync)
    );

    // sync stages plus the agreement flop must fill, else reset zeros get latched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settle_cnt <= 3'h0;
        else if (clk_en && state == hsl_pkg::HSL_WAIT)
            settle_cnt <= settle_cnt + 3'h1;
    end

    // waits for the synchroniser to fill before sampling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= hsl_pkg::HSL_WAIT;
        else if (clk_en)
        begin
            unique case (state)
                hsl_pkg::HSL_WAIT:
                begin
                    if (settle_cnt == hsl_pkg::HSL_SETTLE_CYCLES - 3'h1)
                        state <= hsl_pkg::HSL_SETTLE;
                end
                hsl_pkg::HSL_SETTLE: state <= hsl_pkg::HSL_HELD;
                hsl_pkg::HSL_HELD: state <= hsl_pkg::HSL_HELD;
                default: state <= hsl_pkg::HSL_WAIT;
            endcase
        end
    end

    // RL9: single capture
    assign capture = clk_en && (state == hsl_pkg::HSL_SETTLE);

    // RL9: hold until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap <= hsl_pkg::HSL_STRAP_RST;
        else if (capture)
            strap <= strap_sync;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            straps_valid <= 1'b0;
        else if (capture)
            straps_valid <= 1'b1;
    end

    // port outputs are registered, one cycle after the latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port2_disabled <= 1'b0;
            port3_disabled <= 1'b0;
            port4_disabled <= 1'b0;
            flash_rate_fast <= hsl_pkg::HSL_RATE_SLOW;
        end
        else if (clk_en)
        begin
            // RL1: port 2 off
            // RL4: both bits needed
            port2_disabled <= both_high(strap[hsl_pkg::HSL_P2_PLUS_POS],
                strap[hsl_pkg::HSL_P2_MINUS_POS]);
            // RL2: port 3 off
            port3_disabled <= both_high(strap[hsl_pkg::HSL_P3_PLUS_POS],
                strap[hsl_pkg::HSL_P3_MINUS_POS]);
            // RL3: port 4 off
            port4_disabled <= both_high(strap[hsl_pkg::HSL_P4_PLUS_POS],
                strap[hsl_pkg::HSL_P4_MINUS_POS]);
            // RL5: rate select
            flash_rate_fast <= strap[hsl_pkg::HSL_RATE_POS];
        end
    end

    // shared rate pin: released to the strap until the latch is done
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_rate_pin_o <= 1'b0;
            flash_rate_pin_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            if (!straps_valid)
            begin
                flash_rate_pin_o <= 1'b0;
                flash_rate_pin_oe_n <= 1'b1;
            end
            else if (ctrl[hsl_pkg::HSL_SUSPEND_POS])
            begin
                // RL6: float when fast
                // RL7: drive low when slow
                flash_rate_pin_o <= 1'b0;
                flash_rate_pin_oe_n <= (strap[hsl_pkg::HSL_RATE_POS] == hsl_pkg::HSL_RATE_FAST);
            end
            else
            begin
                flash_rate_pin_o <= flash_rate_pin_out;
                flash_rate_pin_oe_n <= 1'b0;
            end
        end
    end

    // RL8: chip enable high in powerdown
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_ce_n <= 1'b1;
        else if (clk_en)
        begin
            if (!ctrl[hsl_pkg::HSL_FLASH_EN_POS] || ctrl[hsl_pkg::HSL_POWERDOWN_POS])
                flash_ce_n <= 1'b1;
            else
                flash_ce_n <= flash_ce_req_n;
        end
    end

    // apb slave, zero wait states
    assign acc = psel && penable && clk_en;
    assign hit = (paddr == hsl_pkg::HSL_STRAP_OFF) || (paddr == hsl_pkg::HSL_CTRL_OFF)
        || (paddr == hsl_pkg::HSL_STAT_OFF);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= hsl_pkg::HSL_CTRL_RST;
        else if (acc && pwrite && paddr == hsl_pkg::HSL_CTRL_OFF)
            ctrl <= pwdata[2:0];
    end

    // read data prepared at setup so it is valid through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    hsl_pkg::HSL_STRAP_OFF: prdata <= {25'h00_0000, strap};
                    hsl_pkg::HSL_CTRL_OFF: prdata <= {29'h000_0000, ctrl};
                    hsl_pkg::HSL_STAT_OFF: prdata <= {28'h000_0000, straps_valid,
                        port4_disabled, port3_disabled, port2_disabled};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // hub_strap_latch

// >>> hsl_board.sv
`timescale 1ns/10ps
module hsl_board (
    input wire logic [6:0] res,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    output logic [6:0] strap
);
    // the rate pin is shared, so its resistor only sets the level while the hub lets go
    assign strap = {pin_oe_n ? res[6] : pin_o, res[5:0]};
endmodule // hsl_board

// >>> hsl_chk_sva.sv
`timescale 1ns/10ps
module hsl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic port2_plus_off_strap,
    input wire logic port2_minus_off_strap,
    input wire logic port3_plus_off_strap,
    input wire logic port3_minus_off_strap,
    input wire logic port4_plus_off_strap,
    input wire logic port4_minus_off_strap,
    input wire logic flash_rate_strap,
    input wire logic flash_ce_req_n,
    input wire logic port2_disabled,
    input wire logic port3_disabled,
    input wire logic port4_disabled,
    input wire logic flash_rate_fast,
    input wire logic flash_ce_n,
    input wire logic flash_rate_pin_o,
    input wire logic flash_rate_pin_oe_n,
    input wire logic straps_valid
);
    logic [2:0] ctrl;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // control word is not a port, so it is mirrored from apb writes
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ctrl <= 3'h0;
        else if (psel && penable && pready && pwrite && paddr == hsl_pkg::HSL_CTRL_OFF)
            ctrl <= pwdata[2:0];
    a_port2_off:
        assert property ($rose(straps_valid) |=> port2_disabled ==
            $past(port2_plus_off_strap && port2_minus_off_strap)) else $error("port2 off wrong");
    a_port3_off:
        assert property ($rose(straps_valid) |=> port3_disabled ==
            $past(port3_plus_off_strap && port3_minus_off_strap)) else $error("port3 off wrong");
    a_port4_off:
        assert property ($rose(straps_valid) |=> port4_disabled ==
            $past(port4_plus_off_strap && port4_minus_off_strap)) else $error("port4 off wrong");
    a_rate_pick:
        assert property ($rose(straps_valid) |=> flash_rate_fast == $past(flash_rate_strap))
            else $error("rate wrong");
    a_susp_float:
        assert property (straps_valid && $past(straps_valid) && ctrl[1] && flash_rate_fast
            |=> flash_rate_pin_oe_n) else $error("pin not floated");
    a_susp_low:
        assert property (straps_valid && $past(straps_valid) && ctrl[1] && !flash_rate_fast
            |=> !flash_rate_pin_oe_n && !flash_rate_pin_o) else $error("pin not low");
    a_ce_idle:
        assert property (!ctrl[0] || ctrl[2] |=> flash_ce_n) else $error("ce not high");
    a_cfg_hold:
        assert property ($past(straps_valid, 2) |-> straps_valid && $stable({port2_disabled,
            port3_disabled, port4_disabled, flash_rate_fast})) else $error("straps moved");
    cover property (port2_disabled && port4_disabled);
    cover property (ctrl[1] && flash_rate_fast);
    cover property (!flash_ce_n);
endmodule // hsl_chk
bind hub_strap_latch hsl_chk u_chk (.*);

// >>> test_hub_strap_latch.sv
`timescale 1ns/10ps
module test_hub_strap_latch;
    logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, flash_ce_req_n = 1'h1, flash_rate_pin_out = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [6:0] res = 7'h00;
    logic [6:0] sv;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, port2_disabled, port3_disabled, port4_disabled;
    logic flash_rate_fast, flash_ce_n, flash_rate_pin_o, flash_rate_pin_oe_n, straps_valid;
    int n_errors = 0;
    int checks = 0;
    hsl_board board (.res(res), .pin_o(flash_rate_pin_o), .pin_oe_n(flash_rate_pin_oe_n),
        .strap(sv));
    hub_strap_latch DUT (.*, .port2_plus_off_strap(sv[0]), .port2_minus_off_strap(sv[1]),
        .port3_plus_off_strap(sv[2]), .port3_minus_off_strap(sv[3]),
        .port4_plus_off_strap(sv[4]), .port4_minus_off_strap(sv[5]), .flash_rate_strap(sv[6]));
    initial forever #5 pclk = ~pclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rst(input logic [6:0] r);
        res <= r;
        presetn <= 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        repeat (10) @(posedge pclk);
    endtask
    task t_straps;
        logic [6:0] p [7] = '{7'h00, 7'h7F, 7'h15, 7'h2A, 7'h03, 7'h0C, 7'h70};
        for (int i = 0; i < 7; i++)
        begin
            rst(p[i]);
            chk(port2_disabled, &p[i][1:0]); // port 2
            chk(port3_disabled, &p[i][3:2]); // port 3
            chk(port4_disabled, &p[i][5:4]); // port 4
            chk(flash_rate_fast, p[i][6]); // rate
            apb(1'h0, hsl_pkg::HSL_STAT_OFF, 32'h0000_0000);
            chk(rd[3:0], {1'h1, &p[i][5:4], &p[i][3:2], &p[i][1:0]}); // status
            // pins now flip, the latched copy must not
            res <= ~p[i];
            flash_rate_pin_out <= ~p[i][6];
            repeat (10) @(posedge pclk);
            apb(1'h0, hsl_pkg::HSL_STRAP_OFF, 32'h0000_0000);
            chk(rd[6:0], p[i]); // copy
            chk({port2_disabled, port4_disabled, flash_rate_fast},
                {&p[i][1:0], &p[i][5:4], p[i][6]}); // held
        end
        $display("strap test done");
    endtask
    task t_pin;
        for (int r = 0; r < 2; r++)
        begin
            rst({r[0], 6'h00});
            flash_rate_pin_out <= ~r[0];
            repeat (3) @(posedge pclk);
            chk({flash_rate_pin_oe_n, flash_rate_pin_o}, {1'h0, ~r[0]}); // awake
            apb(1'h1, hsl_pkg::HSL_CTRL_OFF, 32'h0000_0002);
            repeat (2) @(posedge pclk);
            chk(flash_rate_pin_oe_n, r[0]); // float or drive
            if (r == 0)
                chk(flash_rate_pin_o, 1'h0); // driven low
            chk(flash_rate_fast, r[0]); // rate kept
        end
        $display("suspend pin test done");
    endtask
    task t_ce;
        rst(7'h00);
        chk(flash_ce_n, 1'h1); // idle high
        flash_ce_req_n <= 1'h0;
        apb(1'h1, hsl_pkg::HSL_CTRL_OFF, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(flash_ce_n, 1'h0); // active low
        clk_en <= 1'h0;
        flash_ce_req_n <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(flash_ce_n, 1'h0); // frozen while disabled
        clk_en <= 1'h1;
        repeat (2) @(posedge pclk);
        chk(flash_ce_n, 1'h1); // follows request
        apb(1'h1, hsl_pkg::HSL_CTRL_OFF, 32'h0000_0005);
        repeat (2) @(posedge pclk);
        chk(flash_ce_n, 1'h1); // powerdown high
        apb(1'h0, hsl_pkg::HSL_CTRL_OFF, 32'h0000_0000);
        chk(rd[2:0], 3'h5); // control readback
        apb(1'h0, 12'h00C, 32'h0000_0000);
        chk({err, rd}, {1'h1, 32'h0000_0000}); // unmapped
        $display("chip enable test done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        give_verdict;
    end
    initial
    begin
        rst(7'h00);
        t_straps;
        t_pin;
        t_ce;
        give_verdict;
    end
endmodule // test_hub_strap_latch
